// [dv/mct_pin_model.sv]
// Pin-side partner: drives count and capture pins, watches match output 0
`timescale 1ns/1ns
module mct_pin_model (
  // Clock
  input  wire logic       core_clk,
  // Pins
  output logic            count_in,
  output logic      [2:0] cap_in,
  input  wire logic [3:0] mat_out
);
  int hi_cnt = 0;

  initial
  begin
    count_in = 1'b0;
    cap_in   = 3'h0;
  end

  // Free-running count of cycles with match output 0 high; bench takes differences
  always @(posedge core_clk)
    hi_cnt <= hi_cnt + int'(mat_out[0]);

  // Each level held w clocks; w below 2 would break the pin spacing limit
  task automatic count_pulses(input int n, input int w);
    repeat (n)
    begin
      @(posedge core_clk);
      count_in <= 1'b1;
      repeat (w) @(posedge core_clk);
      count_in <= 1'b0;
      repeat (w - 1) @(posedge core_clk);
    end
  endtask

  task automatic set_cap(input logic [2:0] v);
    @(posedge core_clk);
    cap_in <= v;
  endtask
endmodule

// [dv/tb_match_capture_timer32.sv]
// Self-checking bench for the match/capture timer
`timescale 1ns/1ns
module tb_match_capture_timer32;
  import mct_pkg::*;
  logic              core_clk;
  logic              arst_n;
  logic [MCT_AW-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic              count_in;
  logic [2:0]        cap_in;
  logic [3:0]        mat_out;
  logic              irq;
  int                err_count;
  int                samples_checked;
  int                cycles;
  int                h0;
  logic [31:0]       rd;
  logic [7:0]        mr0;
  logic [1:0]        src_tab [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  logic [31:0]       pr_tab  [4] = '{32'h0, 32'h0, 32'h0, 32'h1};
  logic [31:0]       tc_tab  [4] = '{32'h5, 32'h5, 32'ha, 32'h5};

  mct_timer u_mct_timer (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .count_in  (count_in),
    .cap_in    (cap_in),
    .mat_out   (mat_out),
    .irq       (irq)
  );

  mct_pin_model u_pins (
    .core_clk (core_clk),
    .count_in (count_in),
    .cap_in   (cap_in),
    .mat_out  (mat_out)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic results();
    $display("Checks: %0d, mismatches: %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // The whole run needs well under 2000 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      err_count++;
      results();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe; sampled 1 ns into it
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wait_pin(input logic v);
    int n;
    n = 0;
    while (mat_out[0] !== v && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(n < 200), 32'h1);
  endtask

  initial
  begin
    arst_n    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    mr0       = {MCT_MR_PAGE, 4'h0};
    wait_cyc(16);
    arst_n <= 1'b1;
    // Reset values of the control block, then one unmapped word
    for (int i = 0; i < 12; i++)
    begin
      reg_read(8'(i * 4), rd);
      chk(rd, MCT_RST_WORD);
    end
    reg_write(8'h2c, 32'hffff_ffff);
    reg_read(8'h2c, rd);
    chk(rd, 32'h0);
    // All four channels match at 10; channel 0 stops; every output action once
    reg_write(MCT_EMR_OFS, 32'h0000_0e43);
    for (int i = 0; i < 4; i++)
      reg_write(mr0 + 8'(4 * i), 32'ha);
    reg_write(MCT_PR_OFS, 32'h1);
    reg_write(MCT_MCR_OFS, 32'h24d);
    reg_write(MCT_MASK_OFS, 32'hf);
    reg_write(MCT_CTRL_OFS, 32'h1);
    wait_cyc(40);
    reg_read(MCT_CTRL_OFS, rd);
    chk(rd, 32'h0);
    reg_read(MCT_TC_OFS, rd);
    chk(rd, 32'ha);
    reg_read(MCT_STAT_OFS, rd);
    chk(rd, 32'hf);
    chk(32'(mat_out), 32'hd);
    chk(32'(irq), 32'h1);
    reg_write(MCT_MASK_OFS, 32'h0);
    reg_read(MCT_STAT_OFS, rd);
    chk(32'(irq), 32'h0);
    reg_write(MCT_MASK_OFS, 32'hf);
    reg_write(MCT_STAT_OFS, 32'hf);
    reg_read(MCT_STAT_OFS, rd);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    // PWM on channel 0, period set by channel 3 reset at 29
    reg_write(MCT_TC_OFS, 32'h0);
    reg_write(MCT_PR_OFS, 32'h0);
    reg_write(MCT_EMR_OFS, 32'h0);
    reg_write(MCT_MCR_OFS, 32'h400);
    reg_write(mr0, 32'h3);
    reg_write(mr0 + 8'hc, 32'h1d);
    reg_write(MCT_MCR_OFS, 32'h1400);
    reg_write(MCT_PWMC_OFS, 32'h1);
    reg_write(MCT_CTRL_OFS, 32'h1);
    wait_cyc(40);
    h0 = u_pins.hi_cnt;
    wait_cyc(60);
    h0 = u_pins.hi_cnt - h0;
    chk(32'(h0 >= 50 && h0 <= 54), 32'h1);
    // Just after the rising edge a reset is far off: the shadow must wait for it
    wait_pin(1'b0);
    wait_pin(1'b1);
    reg_write(mr0, 32'h6);
    reg_read(mr0, rd);
    chk(rd, 32'h3);
    reg_read({MCT_SH_PAGE, 4'h0}, rd);
    chk(rd, 32'h6);
    wait_cyc(40);
    reg_read(mr0, rd);
    chk(rd, 32'h6);
    reg_read(MCT_TC_OFS, rd);
    chk(32'(rd < 32'h1e), 32'h1);
    reg_write(MCT_CTRL_OFS, 32'h0);
    reg_write(MCT_PWMC_OFS, 32'h0);
    reg_write(MCT_MCR_OFS, 32'h0);
    // Pulse width: clear on capture 0 rise, capture 0 on fall, 1 and 2 on rise
    reg_write(MCT_CTCR_OFS, 32'h4);
    reg_write(MCT_CCR_OFS, 32'h16e);
    reg_write(MCT_MASK_OFS, 32'h70);
    reg_write(MCT_CTRL_OFS, 32'h1);
    wait_cyc(5);
    u_pins.set_cap(3'h7);
    wait_cyc(20);
    u_pins.set_cap(3'h0);
    wait_cyc(6);
    reg_write(MCT_CTRL_OFS, 32'h0);
    reg_read({MCT_CR_PAGE, 4'h0}, rd);
    chk(32'(rd >= 32'h13 && rd <= 32'h16), 32'h1);
    reg_read(MCT_STAT_OFS, rd);
    chk(rd, 32'h70);
    chk(32'(irq), 32'h1);
    reg_write(MCT_STAT_OFS, 32'h70);
    reg_write(MCT_CCR_OFS, 32'h0);
    // Counter mode on each edge choice, last row with a prescale of two
    for (int i = 0; i < 4; i++)
    begin
      reg_write(MCT_TC_OFS, 32'h0);
      reg_write(MCT_PC_OFS, 32'h0);
      reg_write(MCT_PR_OFS, pr_tab[i]);
      reg_write(MCT_CTCR_OFS, 32'(src_tab[i]));
      reg_write(MCT_CTRL_OFS, 32'h1);
      u_pins.count_pulses(5, 3);
      wait_cyc(6);
      reg_write(MCT_CTRL_OFS, 32'h0);
      reg_read(MCT_TC_OFS, rd);
      chk(rd, tc_tab[i]);
      reg_read(MCT_PC_OFS, rd);
      chk(rd, 32'h0);
    end
    results();
  end
endmodule

// [hw/mct_edge_sync.sv]
// Two-flop synchroniser with rise and fall pulse detection
`timescale 1ns/1ns
module mct_edge_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // Pins and edge pulses
  input  wire logic [W-1:0] sig_in,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  import mct_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } mct_sync_st_t;

  mct_sync_st_t st_reg;
  mct_sync_st_t st_next;

  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = sig_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Only the second and third stages feed the edge logic
  assign rise = st_reg.s2 & ~st_reg.s3;
  assign fall = ~st_reg.s2 & st_reg.s3;
endmodule

// [hw/mct_match_act.sv]
// Next state of the external match outputs
`timescale 1ns/1ns
module mct_match_act (
  // Present state and control
  input  wire logic [3:0] cur,
  input  wire logic [7:0] ctl,
  input  wire logic [3:0] pwm,
  // Events
  input  wire logic [3:0] hit,
  input  wire logic       prst,
  // Result
  output logic      [3:0] nxt
);
  import mct_pkg::*;

  function automatic logic act_bit(logic c, logic [1:0] a);
    case (mct_act_t'(a))
      MCT_ACT_LOW:  act_bit = 1'b0;
      MCT_ACT_HIGH: act_bit = 1'b1;
      MCT_ACT_TGL:  act_bit = ~c;
      default:      act_bit = c;
    endcase
  endfunction

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      nxt[i] = cur[i];
      if (pwm[i])
      begin
        // Edge at match, low again when the period restarts
        if (hit[i])
          nxt[i] = 1'b1;
        else if (prst)
          nxt[i] = 1'b0;
      end
      else if (hit[i])
        nxt[i] = act_bit(cur[i], ctl[2*i +: 2]);
    end
  end
endmodule

// [hw/mct_pkg.sv]
// Constants and types shared by the match/capture timer design
package mct_pkg;
  localparam int          MCT_NMAT      = 4;
  localparam int          MCT_NCAP      = 3;
  localparam int          MCT_AW        = 8;
  // Register byte offsets
  localparam logic [7:0]  MCT_STAT_OFS  = 8'h00;
  localparam logic [7:0]  MCT_CTRL_OFS  = 8'h04;
  localparam logic [7:0]  MCT_TC_OFS    = 8'h08;
  localparam logic [7:0]  MCT_PR_OFS    = 8'h0c;
  localparam logic [7:0]  MCT_PC_OFS    = 8'h10;
  localparam logic [7:0]  MCT_MCR_OFS   = 8'h14;
  localparam logic [7:0]  MCT_CCR_OFS   = 8'h18;
  localparam logic [7:0]  MCT_CTCR_OFS  = 8'h1c;
  localparam logic [7:0]  MCT_EMR_OFS   = 8'h20;
  localparam logic [7:0]  MCT_PWMC_OFS  = 8'h24;
  localparam logic [7:0]  MCT_MASK_OFS  = 8'h28;
  localparam logic [3:0]  MCT_MR_PAGE   = 4'h3;
  localparam logic [3:0]  MCT_CR_PAGE   = 4'h4;
  localparam logic [3:0]  MCT_SH_PAGE   = 4'h5;
  // Field positions
  localparam int          MCT_CTRL_EN   = 0;
  localparam int          MCT_CTRL_HOLD = 1;
  localparam int          MCT_MCR_INT   = 0;
  localparam int          MCT_MCR_RST   = 1;
  localparam int          MCT_MCR_STOP  = 2;
  localparam int          MCT_MCR_RLD   = 12;
  localparam int          MCT_CCR_RISE  = 0;
  localparam int          MCT_CCR_FALL  = 1;
  localparam int          MCT_CCR_INT   = 2;
  localparam int          MCT_CT_CLREN  = 2;
  localparam int          MCT_CT_CLRCH  = 3;
  localparam int          MCT_CT_CLRFL  = 5;
  localparam int          MCT_EMR_CTL   = 4;
  localparam int          MCT_STAT_CAP  = 4;
  // Reset values
  localparam logic [31:0] MCT_RST_WORD  = 32'h0000_0000;
  localparam logic [3:0]  MCT_RST_EMR   = 4'h0;
  // Count source in the low two bits of CTCR
  typedef enum logic [1:0] {
    MCT_SRC_TIMER = 2'h0,
    MCT_SRC_RISE  = 2'h1,
    MCT_SRC_FALL  = 2'h2,
    MCT_SRC_BOTH  = 2'h3
  } mct_src_t;
  // Match output action
  typedef enum logic [1:0] {
    MCT_ACT_NONE = 2'h0,
    MCT_ACT_LOW  = 2'h1,
    MCT_ACT_HIGH = 2'h2,
    MCT_ACT_TGL  = 2'h3
  } mct_act_t;
endpackage

// [hw/mct_timer.sv]
// Top of the 32-bit match/capture timer with prescaler and register port
//
// Summary of operation
// - 32-bit up counter advancing through a 32-bit prescaler.
// - Counts core clock cycles, or edges of an external count input.
// - Three capture registers latch the count on input edges, optional interrupt.
// - Four match registers; on equality counting continues, optional interrupt.
// - A match can stop the timer, interrupt selected separately.
// - A match can reset the count, interrupt selected separately.
// - Match values pass through shadow registers for glitch-free PWM updates.
// - Four match outputs go low, high, toggle or hold on match.
// - A chosen capture edge can clear both count and prescaler.
// - Match channels can drive single-edge PWM outputs, up to three.
`timescale 1ns/1ns
module mct_timer (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       arst_n,
  // Register port
  input  wire logic [mct_pkg::MCT_AW-1:0] reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  // Pins
  input  wire logic                       count_in,
  input  wire logic [2:0]                 cap_in,
  output logic      [3:0]                 mat_out,
  // Interrupt
  output logic                            irq
);
  import mct_pkg::*;

  typedef struct packed {
    logic [6:0]       stat;
    logic [6:0]       mask;
    logic             en;
    logic             hold;
    logic [31:0]      tc;
    logic [31:0]      pc;
    logic [31:0]      pr;
    logic [15:0]      mcr;
    logic [8:0]       ccr;
    logic [5:0]       ctcr;
    logic [11:0]      emr;
    logic [3:0]       pwmc;
    logic [3:0][31:0] mr;
    logic [3:0][31:0] sh;
    logic [2:0][31:0] cr;
    logic [31:0]      rdata;
  } mct_st_t;

  mct_st_t    st_reg;
  mct_st_t    st_next;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] act_nxt;
  logic       tick;
  logic       inc;
  logic [3:0] hit;
  logic       mat_rst;
  logic       mat_stop;
  logic [2:0] cap_ev;
  logic       cap_clr;
  logic       cnt_edge;
  logic [6:0] st_set;
  logic [6:0] st_clr;

  function automatic logic mcr_bit(logic [15:0] m, int ch, int f);
    mcr_bit = m[3*ch+f];
  endfunction

  function automatic logic ccr_bit(logic [8:0] c, int ch, int f);
    ccr_bit = c[3*ch+f];
  endfunction

  mct_edge_sync #(
    .W (4)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .sig_in   ({count_in, cap_in}),
    .rise     (rise),
    .fall     (fall)
  );

  mct_match_act u_act (
    .cur  (st_reg.emr[3:0]),
    .ctl  (st_reg.emr[11:4]),
    .pwm  (st_reg.pwmc),
    .hit  (hit),
    .prst (mat_rst),
    .nxt  (act_nxt)
  );

  // Event decode from the registered state
  always_comb
  begin
    case (mct_src_t'(st_reg.ctcr[1:0]))
      MCT_SRC_RISE: cnt_edge = rise[3];
      MCT_SRC_FALL: cnt_edge = fall[3];
      MCT_SRC_BOTH: cnt_edge = rise[3] | fall[3];
      default:      cnt_edge = 1'b1;
    endcase
    tick     = st_reg.en && !st_reg.hold && cnt_edge;
    inc      = tick && (st_reg.pc == st_reg.pr);
    mat_rst  = 1'b0;
    mat_stop = 1'b0;
    for (int i = 0; i < MCT_NMAT; i++)
    begin
      hit[i]   = inc && (st_reg.tc == st_reg.mr[i]);
      mat_rst  = mat_rst | (hit[i] & mcr_bit(st_reg.mcr, i, MCT_MCR_RST));
      mat_stop = mat_stop | (hit[i] & mcr_bit(st_reg.mcr, i, MCT_MCR_STOP));
    end
    for (int i = 0; i < MCT_NCAP; i++)
      cap_ev[i] = (rise[i] & ccr_bit(st_reg.ccr, i, MCT_CCR_RISE)) |
                  (fall[i] & ccr_bit(st_reg.ccr, i, MCT_CCR_FALL));
    // Channel select 3 names no input, so the clear stays off
    cap_clr = 1'b0;
    if (st_reg.ctcr[MCT_CT_CLREN] && st_reg.ctcr[MCT_CT_CLRCH +: 2] != 2'h3)
      cap_clr = st_reg.ctcr[MCT_CT_CLRFL] ? fall[st_reg.ctcr[MCT_CT_CLRCH +: 2]]
                                          : rise[st_reg.ctcr[MCT_CT_CLRCH +: 2]];
    for (int i = 0; i < MCT_NMAT; i++)
      st_set[i] = hit[i] & mcr_bit(st_reg.mcr, i, MCT_MCR_INT);
    for (int i = 0; i < MCT_NCAP; i++)
      st_set[MCT_STAT_CAP+i] = cap_ev[i] & ccr_bit(st_reg.ccr, i, MCT_CCR_INT);
    st_clr = (reg_wr && reg_addr == MCT_STAT_OFS) ? reg_wdata[6:0] : 7'h00;
  end

  always_comb
  begin
    st_next = st_reg;
    // Hardware counting first; software writes to the count win below
    if (tick)
      st_next.pc = inc ? 32'h0 : st_reg.pc + 32'h1;
    if (inc)
    begin
      // A stopping match leaves the count on the matched value, unless a reset match in the same cycle clears it
      if (mat_rst)
        st_next.tc = 32'h0;
      else if (!mat_stop)
        st_next.tc = st_reg.tc + 32'h1;
    end
    for (int i = 0; i < MCT_NCAP; i++)
      if (cap_ev[i])
        st_next.cr[i] = st_reg.tc;
    if (cap_clr)
    begin
      st_next.tc = 32'h0;
      st_next.pc = 32'h0;
    end
    // Shadowed values go live only when the period restarts
    for (int i = 0; i < MCT_NMAT; i++)
      if (mat_rst && st_reg.mcr[MCT_MCR_RLD+i])
        st_next.mr[i] = st_reg.sh[i];
    st_next.emr[3:0] = act_nxt;
    if (reg_wr)
    begin
      case (reg_addr)
        MCT_CTRL_OFS:
        begin
          st_next.en   = reg_wdata[MCT_CTRL_EN];
          st_next.hold = reg_wdata[MCT_CTRL_HOLD];
        end
        MCT_TC_OFS:   st_next.tc = reg_wdata;
        MCT_PR_OFS:   st_next.pr = reg_wdata;
        MCT_PC_OFS:   st_next.pc = reg_wdata;
        MCT_MCR_OFS:  st_next.mcr = reg_wdata[15:0];
        MCT_CCR_OFS:  st_next.ccr = reg_wdata[8:0];
        MCT_CTCR_OFS: st_next.ctcr = reg_wdata[5:0];
        MCT_EMR_OFS:  st_next.emr = reg_wdata[11:0];
        MCT_PWMC_OFS: st_next.pwmc = reg_wdata[3:0];
        MCT_MASK_OFS: st_next.mask = reg_wdata[6:0];
        default:
        begin
          if (reg_addr[7:4] == MCT_MR_PAGE)
          begin
            st_next.sh[reg_addr[3:2]] = reg_wdata;
            // Without reload the new value takes effect at once
            if (!st_reg.mcr[MCT_MCR_RLD+reg_addr[3:2]])
              st_next.mr[reg_addr[3:2]] = reg_wdata;
          end
        end
      endcase
    end
    // A hold clears count and prescaler while it stands
    if (st_next.hold)
    begin
      st_next.tc = 32'h0;
      st_next.pc = 32'h0;
    end
    // Stop on match beats a same-cycle enable write
    if (mat_stop)
      st_next.en = 1'b0;
    // New events win over a same-cycle clear
    st_next.stat = (st_reg.stat & ~st_clr) | st_set;
    st_next.rdata = MCT_RST_WORD;
    if (reg_rd)
    begin
      case (reg_addr)
        MCT_STAT_OFS: st_next.rdata = {25'h0, st_reg.stat};
        MCT_CTRL_OFS: st_next.rdata = {30'h0, st_reg.hold, st_reg.en};
        MCT_TC_OFS:   st_next.rdata = st_reg.tc;
        MCT_PR_OFS:   st_next.rdata = st_reg.pr;
        MCT_PC_OFS:   st_next.rdata = st_reg.pc;
        MCT_MCR_OFS:  st_next.rdata = {16'h0, st_reg.mcr};
        MCT_CCR_OFS:  st_next.rdata = {23'h0, st_reg.ccr};
        MCT_CTCR_OFS: st_next.rdata = {26'h0, st_reg.ctcr};
        MCT_EMR_OFS:  st_next.rdata = {20'h0, st_reg.emr};
        MCT_PWMC_OFS: st_next.rdata = {28'h0, st_reg.pwmc};
        MCT_MASK_OFS: st_next.rdata = {25'h0, st_reg.mask};
        default:
        begin
          if (reg_addr[7:4] == MCT_MR_PAGE)
            st_next.rdata = st_reg.mr[reg_addr[3:2]];
          else if (reg_addr[7:4] == MCT_SH_PAGE)
            st_next.rdata = st_reg.sh[reg_addr[3:2]];
          else if (reg_addr[7:4] == MCT_CR_PAGE && reg_addr[3:2] != 2'h3)
            st_next.rdata = st_reg.cr[reg_addr[3:2]];
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg          <= '0;
      st_reg.emr[3:0] <= MCT_RST_EMR;
    end
    else
      st_reg <= st_next;
  end

  assign reg_rdata = st_reg.rdata;
  assign mat_out   = st_reg.emr[3:0];
  assign irq       = |(st_reg.stat & st_reg.mask);

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic sw_cnt;
  assign sw_cnt = reg_wr && (reg_addr == MCT_TC_OFS || reg_addr == MCT_PC_OFS ||
                  reg_addr == MCT_CTRL_OFS);

  logic emr_wr;
  assign emr_wr = reg_wr && reg_addr == MCT_EMR_OFS;

  sequence s_period_rst;
    mat_rst && !sw_cnt;
  endsequence

  sequence s_pwm_edge;
    hit[0] && st_reg.pwmc[0];
  endsequence

  prescale_wrap_a: assert property (inc && !cap_clr && !sw_cnt |=> st_reg.pc == 32'h0)
    else $error("prescaler did not wrap");
  count_step_a: assert property (inc && !mat_rst && !mat_stop && !cap_clr && !sw_cnt
                                 |=> st_reg.tc == $past(st_reg.tc) + 32'h1)
    else $error("count did not step");
  ext_idle_a: assert property (st_reg.ctcr[1:0] != 2'h0 && !rise[3] && !fall[3] && !cap_clr
                               && !sw_cnt |=> $stable(st_reg.pc) && $stable(st_reg.tc))
    else $error("count moved without an external edge");
  capture_load_a: assert property (cap_ev[0] |=> st_reg.cr[0] == $past(st_reg.tc))
    else $error("capture missed the count");
  match_flag_a: assert property (hit[0] && st_reg.mcr[MCT_MCR_INT]
                                 |=> st_reg.stat[0] [*2] or st_reg.stat[0] ##1 !st_reg.stat[0])
    else $error("match flag not set");
  stop_match_a: assert property (mat_stop |=> !st_reg.en ##1 (st_reg.en || !inc))
    else $error("timer kept running after stop");
  reset_match_a: assert property (s_period_rst |=> st_reg.tc == 32'h0)
    else $error("count not reset by match");
  shadow_hold_a: assert property (reg_wr && reg_addr == 8'h30 && st_reg.mcr[MCT_MCR_RLD]
                                  && !mat_rst |=> $stable(st_reg.mr[0]))
    else $error("shadowed match changed early");
  toggle_out_a: assert property (hit[3] && !st_reg.pwmc[3] && st_reg.emr[11:10] == 2'h3
                                 && !(reg_wr && reg_addr == MCT_EMR_OFS)
                                 |=> mat_out[3] != $past(mat_out[3]))
    else $error("match output did not toggle");
  cap_clear_a: assert property (cap_clr && !sw_cnt |=> st_reg.tc == 32'h0 && st_reg.pc == 32'h0)
    else $error("capture clear failed");
  pwm_high_a: assert property ((s_pwm_edge and !(reg_wr && reg_addr == MCT_EMR_OFS))
                               |=> mat_out[0])
    else $error("pwm edge missing");
  pwm_period_a: assert property (s_period_rst ##0 (st_reg.pwmc[0] && !hit[0]
                                 && !(reg_wr && reg_addr == MCT_EMR_OFS)) |=> !mat_out[0])
    else $error("pwm output not low at period start");

  // Count holds, output actions, shadow loads, capture and status upkeep
  stop_hold_a: assert property (mat_stop && !mat_rst && !cap_clr && !sw_cnt
                                |=> $stable(st_reg.tc))
    else $error("count moved past a stopping match");
  idle_hold_a: assert property (!st_reg.en && !cap_clr && !sw_cnt
                                |=> $stable(st_reg.tc) && $stable(st_reg.pc))
    else $error("count moved while disabled");
  prescale_step_a: assert property (tick && !inc && !cap_clr && !sw_cnt
                                    |=> st_reg.pc == $past(st_reg.pc) + 32'h1)
    else $error("prescaler did not step");
  low_out_a: assert property (hit[1] && !st_reg.pwmc[1] && st_reg.emr[7:6] == 2'h1
                              && !emr_wr |=> !mat_out[1])
    else $error("match output not driven low");
  high_out_a: assert property (hit[2] && !st_reg.pwmc[2] && st_reg.emr[9:8] == 2'h2
                               && !emr_wr |=> mat_out[2])
    else $error("match output not driven high");
  none_out_a: assert property (hit[0] && !st_reg.pwmc[0] && st_reg.emr[5:4] == 2'h0
                               && !emr_wr |=> $stable(mat_out[0]))
    else $error("match output moved with no action");
  out_quiet_a: assert property (hit == 4'h0 && !emr_wr |=> $stable(mat_out))
    else $error("match outputs moved without a match");
  shadow_load_a: assert property (mat_rst && st_reg.mcr[MCT_MCR_RLD]
                                  |=> st_reg.mr[0] == $past(st_reg.sh[0]))
    else $error("shadow value not loaded at period restart");
  direct_load_a: assert property (reg_wr && reg_addr == {MCT_MR_PAGE, 4'h0}
                                  && !st_reg.mcr[MCT_MCR_RLD]
                                  |=> st_reg.mr[0] == $past(reg_wdata))
    else $error("unshadowed match write lost");
  shadow_wr_a: assert property (reg_wr && reg_addr == {MCT_MR_PAGE, 4'h4}
                                |=> st_reg.sh[1] == $past(reg_wdata))
    else $error("shadow write lost");
  flag_clear_a: assert property (reg_wr && reg_addr == MCT_STAT_OFS && reg_wdata[0]
                                 && !st_set[0] |=> !st_reg.stat[0])
    else $error("match flag not cleared");
  rst_no_flag_a: assert property (hit[3] && !st_reg.mcr[9] && !st_reg.stat[3]
                                  |=> !st_reg.stat[3])
    else $error("match flag set with its interrupt off");
  rst_keeps_en_a: assert property (mat_rst && !mat_stop && !sw_cnt
                                   |=> st_reg.en == $past(st_reg.en))
    else $error("reset on match changed the enable");
  cap_flag_a: assert property (cap_ev[1] && st_reg.ccr[5] |=> st_reg.stat[5])
    else $error("capture flag not set");
  cap_keep_a: assert property (!cap_ev[1] |=> $stable(st_reg.cr[1]))
    else $error("capture register changed without an edge");
  flag_sticky_a: assert property (st_reg.stat[4] && !(reg_wr && reg_addr == MCT_STAT_OFS
                                  && reg_wdata[4]) |=> st_reg.stat[4])
    else $error("capture flag dropped");
  clear_pick_a: assert property (st_reg.ctcr[MCT_CT_CLREN] && !st_reg.ctcr[MCT_CT_CLRFL]
                                 && st_reg.ctcr[MCT_CT_CLRCH +: 2] == 2'h0
                                 && rise[0] |-> cap_clr)
    else $error("capture clear not taken on the chosen edge");
endmodule
